// ### hw/peak_irq_consts.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Six-bit register addresses on the serial port
// Notes: Definitions only
`ifndef PEAK_IRQ_CONSTS_SVH
`define PEAK_IRQ_CONSTS_SVH

`define ADDR_MODE 6'h09
`define ADDR_IRQ_ENABLE_MASK 6'h0A
`define ADDR_IRQ_STATUS_WORD 6'h0B
`define ADDR_IRQ_STATUS_CLEAR 6'h0C
`define ADDR_CURRENT_PEAK_THRESHOLD 6'h20
`define ADDR_VOLTAGE_PEAK_THRESHOLD 6'h21
`define ADDR_CURRENT_PEAK_RECORD 6'h22
`define ADDR_CURRENT_PEAK_CLEAR 6'h23
`define ADDR_VOLTAGE_PEAK_RECORD 6'h24
`define ADDR_VOLTAGE_PEAK_CLEAR 6'h25
`define ADDR_TEMPERATURE_RESULT 6'h26

`define CMD_WRITE_BIT 6
`define MODE_TEMP_ARM_BIT 5
`define STATUS_ZERO_CROSS_BIT 4
`define STATUS_TEMP_DONE_BIT 5
`define STATUS_VOLTAGE_PEAK_BIT 8
`define STATUS_CURRENT_PEAK_BIT 9

`define RESET_MODE 16'h0000
`define RESET_IRQ_ENABLE_MASK 16'h0000
`define RESET_PEAK_THRESHOLD 8'hFF
`define RESET_TEMPERATURE 8'h00
// cs_n high, sclk low, din low
`define PIN_IDLE 3'h4

`define TEMP_DELAY_QUARTER_TICKS 5'h18
`define LEN_BYTE 5'h08
`define LEN_HALF 5'h10
`define LEN_WORD 5'h18

`endif

// ### hw/peak_irq_pkg.sv
// Purpose: Types shared by the peak and interrupt block
// Assumes: Samples arrive as signed 24-bit words
// Notes: No constants here; see peak_irq_consts.svh
package peak_irq_pkg;

  typedef struct packed {
    logic valid;
    logic [23:0] current;
    logic [23:0] voltage;
  } sample_pair_type;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_CMD = 2'h1,
    SER_DATA = 2'h3
  } serial_state_type;

endpackage

// ### hw/peak_detect_and_interrupt_logic.sv
// Purpose: Peak detection, interrupt status and temperature trigger
// Assumes: Serial pins asynchronous; samples on the core clock
// Notes: Command byte MSB first, bit 6 write, bits 5:0 address
`include "peak_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module peak_detect_and_interrupt_logic (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_sdin,
  input wire logic i_cs_n,
  output logic o_sdout,
  output logic o_sdout_oe,
  output logic o_irq_n,
  output logic o_irq_oe,
  input wire peak_irq_pkg::sample_pair_type i_samples,
  input wire logic i_quarter_tick,
  input wire logic [7:0] i_temp_code
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_stable;
  logic sclk_prev;
  logic cs_active;
  logic sclk_fall;
  logic sclk_rise;

  peak_irq_pkg::serial_state_type ser_state;
  logic [4:0] bit_cnt;
  logic [6:0] cmd_shift;
  logic [22:0] in_shift;
  logic [23:0] out_shift;
  logic [4:0] data_len;
  logic [5:0] cur_addr;
  logic is_write;
  logic [5:0] cmd_addr;
  logic cmd_done;
  logic xfer_done;
  logic [23:0] write_value;

  logic [15:0] mode;
  logic [15:0] irq_enable_mask;
  logic [7:0] voltage_peak_threshold;
  logic [7:0] current_peak_threshold;
  logic [15:0] irq_status_word;
  logic [15:0] next_status;
  logic [15:0] events;
  logic irq_hold;
  logic next_hold;
  logic status_clear_cmd;

  logic [23:0] voltage_peak_record;
  logic [23:0] current_peak_record;
  logic [23:0] v_abs;
  logic [23:0] i_abs;
  logic [24:0] v_dbl;
  logic [24:0] i_dbl;
  logic [23:0] v_rec_val;
  logic voltage_peak_flag;
  logic current_peak_flag;

  logic v_sign_prev;
  logic v_seen;
  logic zero_cross_event;
  logic temp_busy;
  logic [4:0] tick_cnt;
  logic temp_start;
  logic temp_done;
  logic [7:0] temperature_result;

  // Serial pins: three stages, change accepted once stages 2 and 3 agree
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync1 <= `PIN_IDLE;
      sync2 <= `PIN_IDLE;
      sync3 <= `PIN_IDLE;
      pin_stable <= `PIN_IDLE;
      // Idle sclk level, so reset leaves no false edge
      sclk_prev <= 1'b0;
    end else begin
      sync1 <= {i_cs_n, i_sclk, i_sdin};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_stable <= (sync2 & sync3) | (pin_stable & (sync2 ^ sync3));
      sclk_prev <= pin_stable[1];
    end
  end

  assign cs_active = ~pin_stable[2];
  assign sclk_fall = cs_active & sclk_prev & ~pin_stable[1];
  assign sclk_rise = cs_active & ~sclk_prev & pin_stable[1];

  function automatic logic [4:0] reg_len(input logic [5:0] a);
    case (a)
      `ADDR_MODE: reg_len = `LEN_HALF;
      `ADDR_IRQ_ENABLE_MASK: reg_len = `LEN_HALF;
      `ADDR_IRQ_STATUS_WORD: reg_len = `LEN_HALF;
      `ADDR_IRQ_STATUS_CLEAR: reg_len = `LEN_HALF;
      `ADDR_CURRENT_PEAK_RECORD: reg_len = `LEN_WORD;
      `ADDR_CURRENT_PEAK_CLEAR: reg_len = `LEN_WORD;
      `ADDR_VOLTAGE_PEAK_RECORD: reg_len = `LEN_WORD;
      `ADDR_VOLTAGE_PEAK_CLEAR: reg_len = `LEN_WORD;
      default: reg_len = `LEN_BYTE;
    endcase
  endfunction

  // Read data left-justified so the MSB leaves first
  logic [23:0] read_just;
  always_comb begin
    case (cmd_addr)
      `ADDR_MODE: read_just = {mode, 8'h00};
      `ADDR_IRQ_ENABLE_MASK: read_just = {irq_enable_mask, 8'h00};
      `ADDR_IRQ_STATUS_WORD: read_just = {irq_status_word, 8'h00};
      `ADDR_IRQ_STATUS_CLEAR: read_just = {irq_status_word, 8'h00};
      `ADDR_CURRENT_PEAK_THRESHOLD:
        read_just = {current_peak_threshold, 16'h0000};
      `ADDR_VOLTAGE_PEAK_THRESHOLD:
        read_just = {voltage_peak_threshold, 16'h0000};
      `ADDR_CURRENT_PEAK_RECORD: read_just = current_peak_record;
      `ADDR_CURRENT_PEAK_CLEAR: read_just = current_peak_record;
      `ADDR_VOLTAGE_PEAK_RECORD: read_just = voltage_peak_record;
      `ADDR_VOLTAGE_PEAK_CLEAR: read_just = voltage_peak_record;
      `ADDR_TEMPERATURE_RESULT:
        read_just = {temperature_result, 16'h0000};
      default: read_just = 24'h000000;
    endcase
  end

  assign cmd_addr = {cmd_shift[4:0], pin_stable[0]};
  assign cmd_done = (ser_state == peak_irq_pkg::SER_CMD) & sclk_fall &
                    (bit_cnt == 5'h07);
  assign xfer_done = (ser_state == peak_irq_pkg::SER_DATA) & sclk_fall &
                     (bit_cnt == data_len - 5'h01);
  assign write_value = {in_shift, pin_stable[0]} << (`LEN_WORD - data_len);

  // Serial framing: command byte, then one data field per command
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !cs_active) begin
      ser_state <= peak_irq_pkg::SER_IDLE;
      bit_cnt <= 5'h00;
      cmd_shift <= 7'h00;
      in_shift <= 23'h000000;
      out_shift <= 24'h000000;
      data_len <= `LEN_BYTE;
      cur_addr <= 6'h00;
      is_write <= 1'b0;
    end else begin
      case (ser_state)
        peak_irq_pkg::SER_IDLE: begin
          ser_state <= peak_irq_pkg::SER_CMD;
          bit_cnt <= 5'h00;
        end
        peak_irq_pkg::SER_CMD: begin
          if (sclk_fall) begin
            cmd_shift <= {cmd_shift[5:0], pin_stable[0]};
            bit_cnt <= bit_cnt + 5'h01;
            if (cmd_done) begin
              ser_state <= peak_irq_pkg::SER_DATA;
              bit_cnt <= 5'h00;
              cur_addr <= cmd_addr;
              // Byte bit 6 sits one place lower before the last shift
              is_write <= cmd_shift[`CMD_WRITE_BIT - 1];
              data_len <= reg_len(cmd_addr);
              out_shift <= read_just;
            end
          end
        end
        peak_irq_pkg::SER_DATA: begin
          if (sclk_fall) begin
            in_shift <= {in_shift[21:0], pin_stable[0]};
            out_shift <= {out_shift[22:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
            if (xfer_done) begin
              ser_state <= peak_irq_pkg::SER_CMD;
              bit_cnt <= 5'h00;
            end
          end
        end
        default: ser_state <= peak_irq_pkg::SER_IDLE;
      endcase
    end
  end

  // Output bit changes on rising clock so the host samples on falling
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sdout <= 1'b0;
      o_sdout_oe <= 1'b0;
    end else begin
      o_sdout_oe <= cs_active & (ser_state == peak_irq_pkg::SER_DATA) &
                    ~is_write;
      if (sclk_rise && ser_state == peak_irq_pkg::SER_DATA)
        o_sdout <= out_shift[23];
    end
  end

  // Temperature arm bit drops once its conversion starts
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mode <= `RESET_MODE;
      irq_enable_mask <= `RESET_IRQ_ENABLE_MASK;
      voltage_peak_threshold <= `RESET_PEAK_THRESHOLD;
      current_peak_threshold <= `RESET_PEAK_THRESHOLD;
    end else begin
      if (xfer_done && is_write) begin
        case (cur_addr)
          `ADDR_MODE: mode <= write_value[23:8];
          `ADDR_IRQ_ENABLE_MASK: irq_enable_mask <= write_value[23:8];
          `ADDR_VOLTAGE_PEAK_THRESHOLD:
            voltage_peak_threshold <= write_value[23:16];
          `ADDR_CURRENT_PEAK_THRESHOLD:
            current_peak_threshold <= write_value[23:16];
          default: ;
        endcase
      end
      if (temp_start)
        mode[`MODE_TEMP_ARM_BIT] <= 1'b0;
    end
  end

  assign v_abs = i_samples.voltage[23] ? -i_samples.voltage
                                       : i_samples.voltage;
  assign i_abs = i_samples.current[23] ? -i_samples.current
                                       : i_samples.current;
  assign v_dbl = {v_abs, 1'b0};
  assign i_dbl = {i_abs, 1'b0};
  // top byte compare; overflow counts as over any threshold
  assign voltage_peak_flag = i_samples.valid &
    (v_dbl[24] | (v_dbl[23:16] > voltage_peak_threshold));
  assign current_peak_flag = i_samples.valid &
    (i_dbl[24] | (i_dbl[23:16] > current_peak_threshold));
  assign v_rec_val = v_dbl[24] ? 24'hFFFFFF : v_dbl[23:0];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      voltage_peak_record <= 24'h000000;
      current_peak_record <= 24'h000000;
    end else begin
      if (xfer_done && !is_write && cur_addr == `ADDR_VOLTAGE_PEAK_CLEAR)
        voltage_peak_record <= i_samples.valid ? v_rec_val : 24'h000000;
      else if (i_samples.valid && v_rec_val > voltage_peak_record)
        voltage_peak_record <= v_rec_val;
      if (xfer_done && !is_write && cur_addr == `ADDR_CURRENT_PEAK_CLEAR)
        current_peak_record <= i_samples.valid ? i_abs : 24'h000000;
      else if (i_samples.valid && i_abs > current_peak_record)
        current_peak_record <= i_abs;
    end
  end

  assign zero_cross_event = i_samples.valid & v_seen &
                            (i_samples.voltage[23] != v_sign_prev);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      v_sign_prev <= 1'b0;
      v_seen <= 1'b0;
    end else if (i_samples.valid) begin
      v_sign_prev <= i_samples.voltage[23];
      v_seen <= 1'b1;
    end
  end

  assign temp_start = zero_cross_event & mode[`MODE_TEMP_ARM_BIT] &
                      ~temp_busy;
  assign temp_done = temp_busy & i_quarter_tick &
                     (tick_cnt == `TEMP_DELAY_QUARTER_TICKS - 5'h01);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      temp_busy <= 1'b0;
      tick_cnt <= 5'h00;
      temperature_result <= `RESET_TEMPERATURE;
    end else if (temp_start) begin
      temp_busy <= 1'b1;
      tick_cnt <= 5'h00;
    end else if (temp_done) begin
      temp_busy <= 1'b0;
      temperature_result <= i_temp_code;
    end else if (temp_busy && i_quarter_tick) begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  always_comb begin
    events = 16'h0000;
    events[`STATUS_ZERO_CROSS_BIT] = zero_cross_event;
    events[`STATUS_TEMP_DONE_BIT] = temp_done;
    events[`STATUS_VOLTAGE_PEAK_BIT] = voltage_peak_flag;
    events[`STATUS_CURRENT_PEAK_BIT] = current_peak_flag;
  end

  assign status_clear_cmd = cmd_done & ~cmd_shift[`CMD_WRITE_BIT - 1] &
                            (cmd_addr == `ADDR_IRQ_STATUS_CLEAR);
  // set wins over the clear; snapshot taken before it
  assign next_status = events |
                       (irq_status_word & ~{16{status_clear_cmd}});

  // held until last status bit or frame abort
  always_comb begin
    next_hold = irq_hold;
    if (status_clear_cmd)
      next_hold = 1'b1;
    else if (xfer_done || !cs_active)
      next_hold = 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_status_word <= 16'h0000;
      irq_hold <= 1'b0;
      o_irq_n <= 1'b1;
    end else begin
      irq_status_word <= next_status;
      irq_hold <= next_hold;
      o_irq_n <= next_hold | ~(|(next_status & irq_enable_mask));
    end
  end

  // Open drain: only ever pulls low
  assign o_irq_oe = ~o_irq_n;

endmodule // peak_detect_and_interrupt_logic

`default_nettype wire

// ### tb/host_mcu_model.sv
// Purpose: Host controller model on the serial port
// Assumes: 800 ns serial clock, standing low outside frames
// Notes: Read bits are taken 200 ns after each falling edge
`include "peak_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic i_core_clk,
  input wire logic i_sdout,
  input wire logic i_irq_n,
  output logic o_sclk,
  output logic o_sdin,
  output logic o_cs_n
);
  initial begin
    o_sclk = 1'b0;
    o_sdin = 1'b0;
    o_cs_n = 1'b1;
  end
  // command then data
  // Late capture relies on the pin sync holding sdout past the fall
  task automatic xfer(input logic [6:0] cmd, input logic [23:0] wd,
    input int n, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {1'b0, cmd, wd << (24 - n)};
    rd = 24'h0;
    #13;
    o_cs_n = 1'b0;
    #400;
    for (int i = 0; i < n + 8; i++) begin
      // Unused data line toggles so no stale level can pass
      o_sdin = (i < 8 || cmd[6]) ? sh[31 - i] : ~o_sdin;
      o_sclk = 1'b1;
      #400;
      o_sclk = 1'b0;
      #200;
      if (i > 7) begin
        rd = {rd[22:0], i_sdout};
      end
      #200;
    end
    o_cs_n = 1'b1;
    #800;
  endtask
  task automatic service(output logic [23:0] st);
    for (int k = 0; k < 300 && i_irq_n; k++) begin
      @(posedge i_core_clk);
    end
    xfer({1'b0, `ADDR_IRQ_STATUS_CLEAR}, 24'h0, 16, st);
  endtask
endmodule // host_mcu_model
`default_nettype wire

// ### tb/peak_irq_properties.sv
// Purpose: Port checks for the peak and interrupt block
// Assumes: One core clock; serial pins watched raw
// Notes: cs_idle counts cycles with select high
`timescale 1ns/1ps
`default_nettype none
module peak_irq_properties (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_sdin,
  input wire logic i_cs_n,
  input wire logic o_sdout,
  input wire logic o_sdout_oe,
  input wire logic o_irq_n,
  input wire logic o_irq_oe,
  input wire peak_irq_pkg::sample_pair_type i_samples,
  input wire logic i_quarter_tick,
  input wire logic [7:0] i_temp_code
);
  logic [3:0] cs_idle;
  // Saturates so a long idle spell stays visible
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !i_cs_n) begin
      cs_idle <= 4'h0;
    end else if (cs_idle != 4'hF) begin
      cs_idle <= cs_idle + 4'h1;
    end
  end
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  a_oe_follows_irq:
    assert property (o_irq_oe == !o_irq_n) else $error("irq oe mismatch");
  a_reset_quiet:
    assert property (disable iff (1'b0) i_reset |=> o_irq_n && !o_sdout_oe)
    else $error("active in reset");
  a_idle_no_drive:
    assert property (i_cs_n [*6] |-> !o_sdout_oe) else $error("drive idle");
  a_drive_in_frame:
    assert property ($rose(o_sdout_oe) |-> cs_idle == 4'h0)
    else $error("drive outside frame");
  a_release_in_frame:
    assert property ($rose(o_irq_n) |-> cs_idle < 4'hA)
    else $error("irq release idle");
  a_hold_high:
    assert property ($rose(o_irq_n) && cs_idle == 4'h0 |=> o_irq_n [*8])
    else $error("irq not held");
  a_irq_holds_idle:
    assert property (!o_irq_n && cs_idle == 4'hF |=> !o_irq_n)
    else $error("irq dropped idle");
  a_fall_has_cause:
    assert property ($fell(o_irq_n) && cs_idle > 4'h7 |->
      $past(i_samples.valid) || $past(i_quarter_tick))
    else $error("irq fell uncaused");
endmodule // peak_irq_properties
bind peak_detect_and_interrupt_logic peak_irq_properties chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(i_sclk),
  .i_sdin(i_sdin), .i_cs_n(i_cs_n), .o_sdout(o_sdout),
  .o_sdout_oe(o_sdout_oe), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe),
  .i_samples(i_samples), .i_quarter_tick(i_quarter_tick),
  .i_temp_code(i_temp_code)
);
`default_nettype wire

// ### tb/test_peak_detect_and_interrupt_logic.sv
// Purpose: Self-checking bench for the peak and interrupt block
// Assumes: Host model drives the serial pins on its own timing
// Notes: Core-side inputs change on the falling clock edge
`include "peak_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_peak_detect_and_interrupt_logic;
  localparam logic [23:0] CB = 24'h1 << `STATUS_CURRENT_PEAK_BIT;
  localparam logic [23:0] VB = 24'h1 << `STATUS_VOLTAGE_PEAK_BIT;
  localparam logic [23:0] ZB = 24'h1 << `STATUS_ZERO_CROSS_BIT;
  localparam logic [23:0] TB = 24'h1 << `STATUS_TEMP_DONE_BIT;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic qtick = 1'b0;
  logic [7:0] temp_code = 8'hC5;
  peak_irq_pkg::sample_pair_type samples = '0;
  logic sclk, sdin, cs_n, sdout, sdout_oe, irq_n, irq_oe, irq_pin, sdo_pin;
  logic [23:0] rd;
  int num_errors = 0, checks_done = 0, cycles = 0;
  // Pull-up on the open-drain pin; a released sdout reads inverted
  assign irq_pin = irq_oe ? 1'b0 : 1'b1;
  assign sdo_pin = sdout_oe ? sdout : ~sdout;
  always #50 core_clk = ~core_clk;
  peak_detect_and_interrupt_logic uut (
    .i_core_clk(core_clk), .i_reset(reset), .i_sclk(sclk),
    .i_sdin(sdin), .i_cs_n(cs_n), .o_sdout(sdout),
    .o_sdout_oe(sdout_oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe),
    .i_samples(samples), .i_quarter_tick(qtick), .i_temp_code(temp_code)
  );
  host_mcu_model host (
    .i_core_clk(core_clk), .i_sdout(sdo_pin), .i_irq_n(irq_pin),
    .o_sclk(sclk), .o_sdin(sdin), .o_cs_n(cs_n)
  );
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check_reg(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_pin(input string what, input logic exp);
    checks_done++;
    if (irq_pin !== exp || irq_n !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b%b seen %b%b", what, exp, exp,
               irq_pin, irq_n);
    end
  endtask
  task automatic rd_reg(input logic [5:0] a, input int n,
    input logic [23:0] exp, input string what);
    host.xfer({1'b0, a}, 24'h0, n, rd);
    check_reg(what, exp, rd);
  endtask
  task automatic wr_reg(input logic [5:0] a, input int n, input logic [23:0] d);
    host.xfer({1'b1, a}, d, n, rd);
  endtask
  task automatic sample(input logic [23:0] cur, input logic [23:0] vol);
    @(negedge core_clk);
    samples = {1'b1, cur, vol};
    @(negedge core_clk);
    samples.valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge core_clk);
      qtick = 1'b1;
      @(negedge core_clk);
      qtick = 1'b0;
    end
  endtask
  // Run needs about 6000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    repeat (5) @(negedge core_clk);
    rd_reg(`ADDR_IRQ_ENABLE_MASK, 16, 24'h0, "mask");
    rd_reg(`ADDR_CURRENT_PEAK_THRESHOLD, 8, 24'hFF, "ithr");
    rd_reg(6'h3F, 8, 24'h0, "unmapped");
    $display("test reset done");
    wr_reg(`ADDR_IRQ_ENABLE_MASK, 16, CB | VB);
    wr_reg(`ADDR_VOLTAGE_PEAK_THRESHOLD, 8, 24'h10);
    wr_reg(`ADDR_CURRENT_PEAK_THRESHOLD, 8, 24'h10);
    rd_reg(`ADDR_VOLTAGE_PEAK_THRESHOLD, 8, 24'h10, "vthr");
    sample(24'h0A0000, 24'hFFF000);
    check_pin("irq cur", 1'b0);
    rd_reg(`ADDR_VOLTAGE_PEAK_RECORD, 24, 24'h002000, "vrec");
    sample(24'h050000, 24'hF70000);
    rd_reg(`ADDR_CURRENT_PEAK_CLEAR, 24, 24'h0A0000, "iclr");
    rd_reg(`ADDR_CURRENT_PEAK_RECORD, 24, 24'h0, "irec");
    rd_reg(`ADDR_VOLTAGE_PEAK_CLEAR, 24, 24'h120000, "vclr");
    rd_reg(`ADDR_VOLTAGE_PEAK_RECORD, 24, 24'h0, "vrec0");
    fork
      rd_reg(`ADDR_IRQ_STATUS_CLEAR, 16, CB | VB, "status");
      begin
        #12000;
        check_pin("released", 1'b1);
        sample(24'h0A0000, 24'hFFFFFF);
        check_pin("held", 1'b1);
      end
    join
    check_pin("pending", 1'b0);
    host.service(rd);
    check_reg("pend st", CB, rd);
    check_pin("cleared", 1'b1);
    $display("test peaks done");
    wr_reg(`ADDR_IRQ_ENABLE_MASK, 16, 24'h0);
    wr_reg(`ADDR_CURRENT_PEAK_THRESHOLD, 8, 24'h0);
    sample(24'h007FFF, 24'hFFFFFF);
    rd_reg(`ADDR_IRQ_STATUS_CLEAR, 16, 24'h0, "below");
    sample(24'h008000, 24'hFFFFFF);
    check_pin("masked", 1'b1);
    rd_reg(`ADDR_IRQ_STATUS_WORD, 16, CB, "status ro");
    rd_reg(`ADDR_IRQ_STATUS_CLEAR, 16, CB, "zero thr");
    $display("test masked done");
    wr_reg(`ADDR_IRQ_ENABLE_MASK, 16, TB);
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      temp_code = k ? 8'h3A : 8'hC5;
      wr_reg(`ADDR_MODE, 16, 24'h1 << `MODE_TEMP_ARM_BIT);
      sample(24'h0, k ? 24'hFFFF00 : 24'h000100);
      ticks(23);
      rd_reg(`ADDR_TEMPERATURE_RESULT, 8, k ? 24'hC5 : 24'h0, "early");
      check_pin("irq early", 1'b1);
      ticks(1);
      repeat (3) @(negedge core_clk);
      check_pin("irq temp", 1'b0);
      rd_reg(`ADDR_TEMPERATURE_RESULT, 8, temp_code, "temp");
      rd_reg(`ADDR_MODE, 16, 24'h0, "mode");
      rd_reg(`ADDR_IRQ_STATUS_CLEAR, 16, ZB | TB, "temp st");
    end
    $display("test temperature done");
    test_done();
  end
endmodule // test_peak_detect_and_interrupt_logic
`default_nettype wire
